//--- hw/cbt_capture.sv
// Strobe-edge capture of the seven reference code lanes
`timescale 1ns/1ps
module cbt_capture (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic       dqs0_t,
  input  wire logic [6:0] dq_code,
  output logic [6:0]      code,
  output logic            strobe
);
  logic dqs_prev;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dqs_prev <= 1'b0;
      code     <= 7'h00;
      strobe   <= 1'b0;
    end else begin
      dqs_prev <= dqs0_t;
      strobe   <= 1'b0;
      // Every toggle overwrites; the first may be lost, so the host sends four toggles
      if (enable && (dqs0_t != dqs_prev)) begin
        code   <= dq_code;
        strobe <= 1'b1;
      end
    end
  end
endmodule : cbt_capture

//--- hw/cbt_delay.sv
// One-shot delay counter: done rises a fixed count after start
`timescale 1ns/1ps
module cbt_delay #(
  parameter int COUNT = 1
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic cancel,
  output logic      busy,
  output logic      done
);
  logic [cbt_pkg::CNT_W-1:0] cnt;

  always_ff @(posedge mclk) begin
    if (!rst_b || cancel) begin
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt  <= cbt_pkg::CNT_W'(COUNT);
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      cnt  <= cnt - 1'b1;
      done <= (cnt == cbt_pkg::CNT_W'(1));
      busy <= (cnt != cbt_pkg::CNT_W'(1));
    end else begin
      done <= 1'b0;
    end
  end
endmodule : cbt_delay

//--- hw/cbt_pkg.sv
// Constants for the command bus training block
package cbt_pkg;
  // Register offsets (byte addresses), chosen for this block
  localparam logic [7:0] OFF_SETPOINT_TRAINING_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CA_REFERENCE              = 8'h04;
  localparam logic [7:0] OFF_TERMINATION               = 8'h08;
  localparam logic [7:0] OFF_EXTENDED_TERMINATION      = 8'h0c;
  localparam logic [7:0] OFF_DQ_REFERENCE              = 8'h10;
  localparam logic [7:0] OFF_STATUS                    = 8'h14;
  localparam logic [7:0] OFF_STATE_CTRL                = 8'h18;
  // Field positions
  localparam int BIT_TRAIN_EN     = 0;
  localparam int BIT_FAST_CHARGE  = 3;
  localparam int BIT_WRITE_TARGET = 6;
  localparam int BIT_OP_SETPOINT  = 7;
  localparam int BIT_RANGE        = 6;
  localparam int DQ_ODT_LSB       = 0;
  localparam int DQ_ODT_W         = 3;
  localparam int CA_ODT_LSB       = 4;
  // Reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_CA_REF   = 8'h4d;
  localparam logic [7:0] RST_TERM     = 8'h00;
  localparam logic [7:0] RST_EXT_TERM = 8'h00;
  localparam logic [7:0] RST_DQ_REF   = 8'h4d;
  // Timing at 25 MHz
  localparam int CLK_PERIOD_NS     = 40;
  localparam int TRAIN_ENTRY_NS    = 250;
  localparam int SETTLE_LONG_NS    = 250;
  localparam int MRD_NS            = 14;
  localparam int MRW_NS            = 10;
  localparam int TRAIN_ENTRY_CYC   = (TRAIN_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRD_CYC           = (MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRW_CYC           = (MRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_LONG_CYC   = (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 8;
  // Training states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_TRAIN   = 3'b010,
    ST_EXITING = 3'b011,
    ST_RECOVER = 3'b100
  } cbt_state_e;
endpackage : cbt_pkg

//--- hw/cbt_top.sv
// Command bus training mode logic with AHB-Lite mode register access
//
// Overview of operation
// R1: Host finishes command bus training before enabling high-frequency termination.
// R2: After reset the die runs from operating set point zero.
// R3: Host sets write target bit to one and programs set point one first.
// R4: Two mode writes set the training enable bit; the die enters training.
// R5: After mode write delay, CKE low switches the die to set point one; the code selects the inverse of the set point saved at entry.
// R6: In training, strobe zero is input; lanes 6..0 captured on each toggle.
// R7: Lanes 5..0 give reference value, lane 6 the reference range.
// R8: Captured lanes map onto reference bits 6..0 after the entry delay.
// R9: Lane 7 and mask lane 0 are inputs and their level is ignored.
// R10: Lanes 13..8 drive out the CA values captured with chip select.
// R11: Strobe one, mask lane 1 and lanes 15..14 may float.
// R12: Host writes at least one reference setting before the next step.
// R13: Host waits the long settling time after each new reference value.
// R14: DQ termination applies during code entry when termination field enables it.
// R15: Latched CA values appear on the data lanes without clock delay.
// R16: Exit: CKE high, wait settling, then clear enable by two mode writes.
// R17: After exit write the die is ready once the mode write delay elapses.
// R18: On exit the die returns to the set point active before training.
// R19: Training may start from idle or self refresh, not from power-down.
// R20: Entry and exit are identical from idle or self refresh.
// R21: CA termination pad is ignored; only termination registers control CA termination.
// R22: DQ reference range follows bit 6 of the DQ reference register.
// R23: CKE low in training selects the inverse of the programmed set point.
// R24: Host holds CA and CS low until the CKE-low clock delay.
// R25: Host applies two or more strobe pulses per presented code.
`timescale 1ns/1ps
module cbt_top (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Link pins
  input  wire logic        cke,
  input  wire logic        cs,
  input  wire logic [5:0]  ca,
  input  wire logic        ca_termination_pad,
  input  wire logic        self_refresh,
  input  wire logic        power_down,
  input  wire logic        dqs0_t_in,
  input  wire logic [15:0] dq_in,
  input  wire logic [1:0]  mask_invert_lane_in,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe,
  output logic             dqs0_oe,
  output logic             dqs1_oe,
  output logic [1:0]       mask_invert_lane_oe,
  // Device state
  output logic             operating_setpoint,
  output logic             training_active,
  output logic             dq_term_on,
  output logic             ca_term_on,
  output logic             dq_reference_range,
  output logic [6:0]       ca_reference,
  output logic             ready_normal
);
  logic [7:0]             setpoint_training_control_reg;
  logic [7:0]             ca_reference_reg;
  logic [7:0]             termination_reg;
  logic [7:0]             extended_termination_reg;
  logic [7:0]             dq_reference_reg;
  logic                   fsp_saved;
  logic [6:0]             ca_ref_saved;
  logic                   start_allowed;
  cbt_pkg::cbt_state_e    state;
  cbt_pkg::cbt_state_e    next_state;
  // Bus pipeline
  logic                   ap_valid;
  logic                   ap_write;
  logic [7:0]             ap_addr;
  logic                   wr_en;
  logic [31:0]            next_rdata;
  logic                   rd_take;
  logic [7:0]             rd_addr;
  // Timers, captured code and decoded training writes
  logic                   mrd_start;
  logic                   mrd_busy;
  logic                   mrd_done;
  logic                   ent_start;
  logic                   ent_busy;
  logic                   ent_done;
  logic                   mrw_start;
  logic                   mrw_busy;
  logic                   mrw_done;
  logic                   mrd_met;
  logic [6:0]             cap_code;
  logic                   cap_strobe;
  logic                   code_pending;
  logic                   train_en_wr;
  logic                   train_dis_wr;
  logic [6:0]             ca_latched;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = ap_valid && ap_write;
  // Reads decode in the address phase so their data stand through the data phase
  assign rd_take   = hready && hsel && htrans[1] && !hwrite;
  assign rd_addr   = {haddr[7:2], 2'b00};

  // Decoded mode writes that start or end training
  assign train_en_wr  = wr_en && ap_addr == cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL
                        && hwdata[cbt_pkg::BIT_TRAIN_EN];
  assign train_dis_wr = wr_en && ap_addr == cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL
                        && !hwdata[cbt_pkg::BIT_TRAIN_EN];
  // Entry allowed from idle or from self refresh outside power-down
  assign start_allowed = !power_down && cke; // R19 R20

  // Address phase kept for the data phase that follows
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= {haddr[7:2], 2'b00};
    end
  end

  // Mode registers; one copy each, writes ignore the write target bit (no set point 0/1 image)
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      setpoint_training_control_reg <= cbt_pkg::RST_CONTROL; // R2
      termination_reg               <= cbt_pkg::RST_TERM;
      extended_termination_reg      <= cbt_pkg::RST_EXT_TERM;
      dq_reference_reg              <= cbt_pkg::RST_DQ_REF;
    end else if (wr_en) begin
      unique case (ap_addr)
        cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL: begin
          // Refused entry drops the enable bit so software can see it
          if (state == cbt_pkg::ST_IDLE && hwdata[cbt_pkg::BIT_TRAIN_EN] && !start_allowed)
            setpoint_training_control_reg <= hwdata[7:0] & 8'hfe;
          else
            setpoint_training_control_reg <= hwdata[7:0]; // R4 R16
        end
        cbt_pkg::OFF_TERMINATION:          termination_reg          <= hwdata[7:0];
        cbt_pkg::OFF_EXTENDED_TERMINATION: extended_termination_reg <= hwdata[7:0];
        cbt_pkg::OFF_DQ_REFERENCE:         dq_reference_reg         <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // CA reference: software write, or captured code after the entry delay
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ca_reference_reg <= cbt_pkg::RST_CA_REF;
      code_pending     <= 1'b0;
    end else begin
      // A code left over from an earlier training pass must not land later
      if (state != cbt_pkg::ST_TRAIN)
        code_pending <= 1'b0;
      else if (cap_strobe)
        code_pending <= 1'b1;
      if (state == cbt_pkg::ST_TRAIN && !ent_busy && (code_pending || cap_strobe)) begin
        ca_reference_reg[6:0] <= cap_code; // R8
        code_pending          <= 1'b0;
      end else if (state == cbt_pkg::ST_RECOVER && mrw_done) begin
        ca_reference_reg[6:0] <= ca_ref_saved; // R18
      end else if (wr_en && ap_addr == cbt_pkg::OFF_CA_REFERENCE) begin
        ca_reference_reg <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mrd_met <= 1'b0;
    end else begin
      // CKE is only looked at once the mode write delay has run out
      if (state != cbt_pkg::ST_ARMED)
        mrd_met <= 1'b0;
      else if (mrd_done)
        mrd_met <= 1'b1;
    end
  end

  // The exit write is taken in the armed or exiting state, not in training; CKE low again
  // before that write re-enters training under the alternate set point
  always_comb begin
    next_state = state;
    unique case (state)
      cbt_pkg::ST_IDLE:
        if (train_en_wr && start_allowed)
          next_state = cbt_pkg::ST_ARMED; // R4
      cbt_pkg::ST_ARMED:
        if (train_dis_wr)
          next_state = cbt_pkg::ST_RECOVER;
        else if (mrd_met && !cke)
          next_state = cbt_pkg::ST_TRAIN; // R5 R23
      cbt_pkg::ST_TRAIN:
        if (cke)
          next_state = cbt_pkg::ST_EXITING; // R16
      cbt_pkg::ST_EXITING:
        if (train_dis_wr)
          next_state = cbt_pkg::ST_RECOVER;
        else if (!cke)
          next_state = cbt_pkg::ST_TRAIN;
      cbt_pkg::ST_RECOVER:
        if (mrw_done)
          next_state = cbt_pkg::ST_IDLE; // R17
      default: next_state = cbt_pkg::ST_IDLE;
    endcase
  end

  // Reset returns to idle from any state
  always_ff @(posedge mclk) begin
    if (!rst_b)
      state <= cbt_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Save the active set point at entry, switch to the alternate on CKE low
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      operating_setpoint <= 1'b0; // R2
      fsp_saved          <= 1'b0;
      ca_ref_saved       <= cbt_pkg::RST_CA_REF[6:0];
    end else begin
      if (state == cbt_pkg::ST_IDLE && next_state == cbt_pkg::ST_ARMED) begin
        fsp_saved    <= setpoint_training_control_reg[cbt_pkg::BIT_OP_SETPOINT];
        ca_ref_saved <= ca_reference_reg[6:0];
      end
      if (state != cbt_pkg::ST_TRAIN && next_state == cbt_pkg::ST_TRAIN)
        operating_setpoint <= !fsp_saved; // R5 R23
      else if (state == cbt_pkg::ST_TRAIN && next_state == cbt_pkg::ST_EXITING)
        operating_setpoint <= fsp_saved; // R18
      else if (state == cbt_pkg::ST_IDLE)
        operating_setpoint <= setpoint_training_control_reg[cbt_pkg::BIT_OP_SETPOINT];
    end
  end

  // Each delay runs from the transition that starts it
  assign mrd_start = state == cbt_pkg::ST_IDLE && next_state == cbt_pkg::ST_ARMED;
  assign ent_start = state == cbt_pkg::ST_ARMED && next_state == cbt_pkg::ST_TRAIN;
  assign mrw_start = state != cbt_pkg::ST_RECOVER && next_state == cbt_pkg::ST_RECOVER;

  cbt_delay #(.COUNT(cbt_pkg::MRD_CYC)) u_mrd (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .start  (mrd_start),
    .cancel (1'b0),
    .busy   (mrd_busy),
    .done   (mrd_done)
  );

  // Cancelled on return to idle so a later entry starts it afresh
  cbt_delay #(.COUNT(cbt_pkg::TRAIN_ENTRY_CYC)) u_entry (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .start  (ent_start),
    .cancel (state == cbt_pkg::ST_IDLE),
    .busy   (ent_busy),
    .done   (ent_done)
  );

  cbt_delay #(.COUNT(cbt_pkg::MRW_CYC)) u_mrw (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .start  (mrw_start),
    .cancel (1'b0),
    .busy   (mrw_busy),
    .done   (mrw_done)
  );

  // Lanes 7 and mask lanes are not passed in: their level is ignored
  cbt_capture u_capture (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .enable  (state == cbt_pkg::ST_TRAIN), // R6
    .dqs0_t  (dqs0_t_in),
    .dq_code (dq_in[6:0]), // R7 R9
    .code    (cap_code),
    .strobe  (cap_strobe)
  );

  // CA levels latched on chip select, returned on lanes 13..8
  always_ff @(posedge mclk) begin
    if (!rst_b)
      ca_latched <= 7'h00;
    else if (state == cbt_pkg::ST_TRAIN && cs)
      ca_latched <= {1'b0, ca};
  end

  always_comb begin
    dq_out       = 16'h0000;
    dq_out[13:8] = (cs ? ca : ca_latched[5:0]); // R10 R15
    dq_oe        = (state == cbt_pkg::ST_TRAIN) ? 16'h3f00 : 16'h0000; // R10 R11
  end

  // Strobes and mask lanes stay inputs; lanes 15..14 and 7..0 float, lanes 13..8 are driven only in training
  assign dqs0_oe             = 1'b0; // R6
  assign dqs1_oe             = 1'b0; // R11
  assign mask_invert_lane_oe = 2'b00; // R9 R11
  assign training_active     = state == cbt_pkg::ST_TRAIN;
  assign dq_term_on  = state == cbt_pkg::ST_TRAIN
                       && termination_reg[cbt_pkg::DQ_ODT_LSB +: cbt_pkg::DQ_ODT_W] != 3'h0; // R14
  // The CA pad level takes no part in CA termination
  assign ca_term_on  = termination_reg[cbt_pkg::CA_ODT_LSB +: cbt_pkg::DQ_ODT_W] != 3'h0
                       || extended_termination_reg[cbt_pkg::DQ_ODT_W-1:0] != 3'h0; // R21
  assign dq_reference_range = dq_reference_reg[cbt_pkg::BIT_RANGE]; // R22
  assign ca_reference       = ca_reference_reg[6:0];
  // Idle is reached only after the exit delay has run out
  assign ready_normal       = state == cbt_pkg::ST_IDLE; // R17

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (rd_addr)
      cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL: next_rdata[7:0] = setpoint_training_control_reg;
      cbt_pkg::OFF_CA_REFERENCE:          next_rdata[7:0] = ca_reference_reg;
      cbt_pkg::OFF_TERMINATION:           next_rdata[7:0] = termination_reg;
      cbt_pkg::OFF_EXTENDED_TERMINATION:  next_rdata[7:0] = extended_termination_reg;
      cbt_pkg::OFF_DQ_REFERENCE:          next_rdata[7:0] = dq_reference_reg;
      // Status from bit 0 up: state, training, set point, ready
      cbt_pkg::OFF_STATUS:
        next_rdata[5:0] = {ready_normal, operating_setpoint, training_active, state};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data load on a read address phase and then hold; a read issued right
  // behind a write to the same register returns the value before the write
  always_ff @(posedge mclk) begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= next_rdata;
  end
endmodule : cbt_top

//--- tb/cbt_host_model.sv
// Host controller model driving the training pins
`timescale 1ns/1ps
module cbt_host_model #(
  parameter int CKE_LOW_CLK_CYC = 3
) (
  input  wire logic  mclk,
  output logic       cke,
  output logic       cs,
  output logic [5:0] ca,
  output logic       dqs0_t_in,
  output logic [15:0] dq_in
);
  logic [8:0] float_q = 9'h0a5;
  logic [6:0] code_q  = 7'h00;
  initial begin
    cke = 1'b1;
    cs = 1'b0;
    ca = 6'h00;
    dqs0_t_in = 1'b0;
  end
  // Undriven upper lanes change every cycle
  always @(posedge mclk) float_q <= ~float_q;
  assign dq_in = {float_q, code_q};
  task automatic enter();
    repeat (cbt_pkg::MRD_CYC + 1) @(posedge mclk);
    cke <= 1'b0;
    repeat (CKE_LOW_CLK_CYC) @(posedge mclk);
  endtask : enter
  task automatic send_code(input logic [6:0] code);
    @(posedge mclk);
    code_q <= code;
    repeat (4) begin
      @(posedge mclk);
      dqs0_t_in <= ~dqs0_t_in;
    end
    @(posedge mclk);
    code_q <= ~code;
    repeat (cbt_pkg::SETTLE_LONG_CYC + cbt_pkg::TRAIN_ENTRY_CYC) @(posedge mclk);
  endtask : send_code
  task automatic ca_echo(input logic [5:0] v);
    @(posedge mclk);
    cs <= 1'b1;
    ca <= v;
    @(posedge mclk);
    cs <= 1'b0;
    ca <= ~v;
  endtask : ca_echo
  task automatic leave();
    @(posedge mclk);
    cke <= 1'b1;
    repeat (cbt_pkg::SETTLE_LONG_CYC) @(posedge mclk);
  endtask : leave
endmodule : cbt_host_model

//--- tb/cbt_properties.sv
// Concurrent checks on the training block ports
`timescale 1ns/1ps
module cbt_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        cke,
  input wire logic        cs,
  input wire logic [5:0]  ca,
  input wire logic        power_down,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe,
  input wire logic        dqs0_oe,
  input wire logic [1:0]  mask_invert_lane_oe,
  input wire logic        operating_setpoint,
  input wire logic        training_active,
  input wire logic        dq_term_on,
  input wire logic [6:0]  ca_reference,
  input wire logic        ready_normal
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic sp_hi;
  // Set point in force while idle, kept through training
  always_ff @(posedge mclk) begin
    if (!rst_b) sp_hi <= 1'b0;
    else if (cke && ready_normal) sp_hi <= operating_setpoint;
  end
  sequence s_enter;
    $fell(cke) && !ready_normal;
  endsequence
  sequence s_leave;
    $rose(cke) && training_active;
  endsequence
  a_bus_resp_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  a_lane_dir_train: assert property (training_active |->
    dq_oe == 16'h3f00 && !dqs0_oe && mask_invert_lane_oe == 2'b00)
    else $error("lane directions wrong in training");
  a_lane_dir_idle: assert property (!training_active |-> dq_oe == 16'h0000)
    else $error("lanes driven outside training");
  a_ca_echo_live: assert property (training_active && cs |-> dq_out[13:8] == ca)
    else $error("live command echo wrong");
  a_ca_echo_hold: assert property (training_active && !cs && $past(cs)
    && $past(training_active) |-> dq_out[13:8] == $past(ca))
    else $error("held command echo wrong");
  a_setpoint_flip: assert property (s_enter |-> ##[1:2] operating_setpoint != sp_hi)
    else $error("set point not swapped on entry");
  a_setpoint_back: assert property (s_leave |-> ##[1:2] operating_setpoint == sp_hi)
    else $error("set point not restored on exit");
  a_ref_hold_entry: assert property ($rose(training_active) |=> $stable(ca_reference)[*6])
    else $error("reference changed before entry delay");
  a_term_scope: assert property (dq_term_on |-> training_active)
    else $error("data termination outside training");
  a_ready_excl: assert property (training_active |-> !ready_normal)
    else $error("ready while training");
  a_pd_refused: assert property (power_down && ready_normal |=> ready_normal)
    else $error("entry taken in power-down");
endmodule : cbt_properties

bind cbt_top cbt_properties cbt_properties_inst (
  .mclk(mclk), .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp), .cke(cke),
  .cs(cs), .ca(ca), .power_down(power_down), .dq_out(dq_out), .dq_oe(dq_oe),
  .dqs0_oe(dqs0_oe), .mask_invert_lane_oe(mask_invert_lane_oe),
  .operating_setpoint(operating_setpoint), .training_active(training_active),
  .dq_term_on(dq_term_on), .ca_reference(ca_reference), .ready_normal(ready_normal)
);

//--- tb/testbench.sv
// Self-checking bench for the command bus training block
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        cke, cs, ca_termination_pad, self_refresh, power_down, dqs0_t_in;
  logic [5:0]  ca;
  logic [15:0] dq_in, dq_out, dq_oe;
  logic        dqs0_oe, dqs1_oe, operating_setpoint, training_active;
  logic        dq_term_on, ca_term_on, dq_reference_range, ready_normal;
  logic [1:0]  mask_invert_lane_oe;
  logic [6:0]  ca_reference;
  int          bad_count = 0;
  int          tests_run = 0;
  always #20 mclk = ~mclk;
  assign hready = hreadyout;
  cbt_top cbt_top_inst (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cke(cke), .cs(cs), .ca(ca),
    .ca_termination_pad(ca_termination_pad), .self_refresh(self_refresh),
    .power_down(power_down), .dqs0_t_in(dqs0_t_in), .dq_in(dq_in),
    .mask_invert_lane_in(dq_in[8:7]), .dq_out(dq_out), .dq_oe(dq_oe), .dqs0_oe(dqs0_oe),
    .dqs1_oe(dqs1_oe), .mask_invert_lane_oe(mask_invert_lane_oe),
    .operating_setpoint(operating_setpoint), .training_active(training_active),
    .dq_term_on(dq_term_on), .ca_term_on(ca_term_on),
    .dq_reference_range(dq_reference_range), .ca_reference(ca_reference),
    .ready_normal(ready_normal));
  cbt_host_model cbt_host_model_inst (.mclk(mclk), .cke(cke), .cs(cs), .ca(ca),
    .dqs0_t_in(dqs0_t_in), .dq_in(dq_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(rd, {24'h0, exp});
  endtask : rreg
  task automatic results();
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    results();
  end
  initial begin
    logic [7:0] offs [5] = '{cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, cbt_pkg::OFF_CA_REFERENCE,
      cbt_pkg::OFF_TERMINATION, cbt_pkg::OFF_EXTENDED_TERMINATION, cbt_pkg::OFF_DQ_REFERENCE};
    logic [7:0] rsts [5] = '{cbt_pkg::RST_CONTROL, cbt_pkg::RST_CA_REF, cbt_pkg::RST_TERM,
      cbt_pkg::RST_EXT_TERM, cbt_pkg::RST_DQ_REF};
    logic [6:0] codes [2] = '{7'h25, 7'h5a};
    logic [7:0] ctl;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ca_termination_pad = 1'b0;
    self_refresh = 1'b0;
    power_down = 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) rreg(offs[i], rsts[i]);
    chk(operating_setpoint, 0);
    ahb(8'h40, 1'b1, 32'hff);
    rreg(8'h40, 8'h00);
    $display("reset values test done");
    @(posedge mclk);
    power_down <= 1'b1;
    ahb(cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, 1'b1, 32'h41);
    rreg(cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, 8'h40);
    chk(ready_normal, 1);
    power_down <= 1'b0;
    $display("power-down refusal test done");
    ahb(cbt_pkg::OFF_TERMINATION, 1'b1, 32'h01);
    for (int i = 0; i < 2; i++) begin
      self_refresh <= i[0];
      ctl = {i[0], 7'h40};
      ahb(cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, 1'b1, {24'h0, ctl});
      ahb(cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, 1'b1, {24'h0, ctl | 8'h01});
      ca_termination_pad <= 1'b1;
      cbt_host_model_inst.enter();
      @(negedge mclk);
      chk(training_active, 1);
      chk(operating_setpoint, !i[0]);
      chk(dq_oe, 16'h3f00);
      chk(dq_term_on, 1);
      chk(ca_term_on, 0);
      chk(dqs1_oe, 0);
      cbt_host_model_inst.send_code(codes[i]);
      chk(ca_reference, codes[i]);
      cbt_host_model_inst.ca_echo(6'h2a ^ 6'(i));
      @(negedge mclk);
      chk(dq_out[13:8], 6'h2a ^ 6'(i));
      cbt_host_model_inst.leave();
      @(negedge mclk);
      chk(operating_setpoint, i[0]);
      ahb(cbt_pkg::OFF_SETPOINT_TRAINING_CONTROL, 1'b1, {24'h0, ctl});
      repeat (cbt_pkg::MRW_CYC + 2) @(negedge mclk);
      chk(ready_normal, 1);
      chk(ca_reference, cbt_pkg::RST_CA_REF);
      chk(dq_term_on, 0);
      $display("training pass %0d test done", i);
    end
    ahb(cbt_pkg::OFF_EXTENDED_TERMINATION, 1'b1, 32'h01);
    @(negedge mclk);
    chk(ca_term_on, 1);
    ahb(cbt_pkg::OFF_DQ_REFERENCE, 1'b1, 32'h40);
    @(negedge mclk);
    chk(dq_reference_range, 1);
    ahb(cbt_pkg::OFF_DQ_REFERENCE, 1'b1, 32'h0d);
    @(negedge mclk);
    chk(dq_reference_range, 0);
    $display("termination and range test done");
    results();
  end
endmodule : testbench
